// ===== src/pdsp_pkg.sv
// Shared constants and types for the source port policy and its far end.
// Assumes one 100 MHz clock shared by both ends and a synchronous reset.
package pdsp_pkg;

  // ----------------------------------------------------------------------
  // Packet addressing and message codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PDSP_SOP   = 2'h0,
    PDSP_SOP_P = 2'h1,
    PDSP_SOP_PP = 2'h2,
    PDSP_HRST  = 2'h3
  } pdsp_addr_e;

  typedef enum logic [3:0] {
    PDSP_MSG_NONE     = 4'h0,
    PDSP_MSG_SRC_CAP  = 4'h1,
    PDSP_MSG_GOODCRC  = 4'h2,
    PDSP_MSG_REQUEST  = 4'h3,
    PDSP_MSG_ACCEPT   = 4'h4,
    PDSP_MSG_REJECT   = 4'h5,
    PDSP_MSG_PS_RDY   = 4'h6,
    PDSP_MSG_SOFT_RST = 4'h7,
    PDSP_MSG_PR_SWAP  = 4'h8,
    PDSP_MSG_DR_SWAP  = 4'h9,
    PDSP_MSG_VC_SWAP  = 4'ha,
    PDSP_MSG_DISC_ID  = 4'hb,
    PDSP_MSG_MODE     = 4'hc
  } pdsp_msg_e;

  // ----------------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------------
  localparam int PDSP_CLK_NS       = 10;
  localparam int PDSP_CAP_US       = 100;
  localparam int PDSP_RECV_US      = 1;
  localparam int PDSP_NORESP_US    = 500;
  localparam int PDSP_CAP_CYC      = (PDSP_CAP_US * 1000) / PDSP_CLK_NS;
  localparam int PDSP_RECV_CYC     = (PDSP_RECV_US * 1000) / PDSP_CLK_NS;
  localparam int PDSP_NORESP_CYC   = (PDSP_NORESP_US * 1000) / PDSP_CLK_NS;
  localparam int PDSP_HRST_RETRIES = 2;
  localparam int PDSP_TMR_W        = 24;
  localparam logic [7:0] PDSP_DEF_CUR = 8'h1e;  // 3A in 100 mA units

endpackage : pdsp_pkg

// ===== src/pdsp_cc_if.sv
// Shared CC wire carrying one SOP* message per valid cycle in each direction.
// Assumes both ends sit on the same clock; no clocking block is used.
`timescale 1ns/1ps
interface pdsp_cc_if;
  import pdsp_pkg::*;
  logic       src_valid;
  pdsp_addr_e src_addr;
  pdsp_msg_e  src_msg;
  logic [7:0] src_data;
  logic       snk_valid;
  pdsp_addr_e snk_addr;
  pdsp_msg_e  snk_msg;
  logic [7:0] snk_data;

  modport source (output src_valid, src_addr, src_msg, src_data,
                  input  snk_valid, snk_addr, snk_msg, snk_data);
  modport partner (input  src_valid, src_addr, src_msg, src_data,
                   output snk_valid, snk_addr, snk_msg, snk_data);
endinterface : pdsp_cc_if

// ===== src/pdsp_timer.sv
// Down counter used for every protocol timer of the source end.
// Assumes load and count share the clock; expiry is a one-cycle pulse.
`timescale 1ns/1ps
module pdsp_timer import pdsp_pkg::*; #(
  parameter int W = PDSP_TMR_W
) (
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         stop,
  output logic              expired
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_expired;
  always_comb begin
    next_cnt     = cnt;
    next_expired = 1'b0;
    if (load) begin
      next_cnt = value;
    end else if (stop) begin
      next_cnt = '0;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_expired = (cnt == W'(1));
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt     <= '0;
      expired <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule : pdsp_timer

// ===== src/pdsp_source.sv
// Source port policy: attach roles, cable probing, contract, swaps, resets.
// Assumes the PHY below delivers whole messages on the CC interface and
// answers GoodCRC itself for the partner; timers are build-time values.
`timescale 1ns/1ps
// Functional notes
// - Far plug: non-VCONN end answers double-prime only
// - Far plug: double-prime only with single-prime support
// - Far plug ignores plain SOP traffic
// - Port traffic beats plug traffic, no reset
// - Pre-contract plug query only when VCONN supplier
// - Sink discards single-prime before contract
// - Only VCONN supplier talks to plug
// - Mode packets need DFP and VCONN
// - Pull-up end is Source, DFP, VCONN
// - Probe cable first; no reply means 3A
// - Resend capabilities at fixed interval; after a hard reset the code sends them once and waits NORESP_CYC
// - PD capable on GoodCRC or hard reset
// - Request gets Accept, then PS_RDY, contract
// - Ready state resends capabilities on change
// - Power swap gives Sink with implicit contract; the code clears CONTRACT instead
// - Data swap keeps power and VCONN roles
// - VCONN swap drives both before release
// - SOP traffic ends cable exchange at once
// - No GoodCRC: soft reset, then hard reset
// - Error during transition forces hard reset
// - Soft reset keeps contract, roles, modes
// - Hard reset restores DFP, VCONN, exits modes
// - Silent partner: limited hard resets, then recovery
module pdsp_source import pdsp_pkg::*; #(
  parameter int CAP_CYC   = PDSP_CAP_CYC,
  parameter int RECV_CYC  = PDSP_RECV_CYC,
  parameter int NORESP_CYC = PDSP_NORESP_CYC,
  parameter int HRST_MAX  = PDSP_HRST_RETRIES
) (
  input  wire logic   CLK,
  input  wire logic   RESET,
  input  wire logic   ATTACH,
  input  wire logic   CAPS_CHANGED,
  input  wire logic   SUPPLY_READY,
  input  wire logic   SUPPLY_FAULT,
  input  wire logic   REQ_PR_SWAP,
  input  wire logic   REQ_DR_SWAP,
  input  wire logic   REQ_VC_SWAP,
  input  wire logic   REQ_MODE,
  input  wire logic   VCONN_PEER_ON,
  pdsp_cc_if.source   cc,
  output logic        IS_SOURCE,
  output logic        IS_DFP,
  output logic        VCONN_ON,
  output logic        CONTRACT,
  output logic        IN_MODE,
  output logic        ERROR_RECOVERY,
  output logic [7:0]  CABLE_CUR
);
  typedef enum logic [10:0] {
    S_IDLE    = 11'h001,
    S_PROBE   = 11'h002,
    S_CAPS    = 11'h004,
    S_NEGO    = 11'h008,
    S_TRANS   = 11'h010,
    S_READY   = 11'h020,
    S_WAITACK = 11'h040,
    S_SOFT    = 11'h080,
    S_HARD    = 11'h100,
    S_VCSWAP  = 11'h200,
    S_ERR     = 11'h400
  } pdsp_st_e;

  pdsp_st_e   st, next_st;
  logic       next_is_source, next_is_dfp, next_vconn, next_contract;
  logic       next_in_mode, next_err, pd_cap, next_pd_cap;
  logic [7:0] next_cable;
  logic [1:0] hcnt, next_hcnt;
  logic       tx_v, next_tx_v;
  pdsp_addr_e tx_a, next_tx_a;
  pdsp_msg_e  tx_m, next_tx_m;
  logic [7:0] tx_d, next_tx_d;
  logic       t_load, t_exp, t_stop;
  logic [PDSP_TMR_W-1:0] t_val;
  logic       rx_sop, rx_hrst, rx_ack, plug_busy;
  assign cc.src_valid = tx_v;
  assign cc.src_addr  = tx_a;
  assign cc.src_msg   = tx_m;
  assign cc.src_data  = tx_d;
  // Plug replies are only recognised while this end supplies VCONN
  assign rx_sop  = cc.snk_valid && cc.snk_addr == PDSP_SOP;
  assign rx_hrst = cc.snk_valid && cc.snk_addr == PDSP_HRST;
  assign rx_ack  = rx_sop && cc.snk_msg == PDSP_MSG_GOODCRC;
  assign plug_busy = st == S_PROBE;
  pdsp_timer u_tmr (
    .CLK     (CLK),
    .RESET   (RESET),
    .load    (t_load),
    .value   (t_val),
    .stop    (t_stop),
    .expired (t_exp)
  );
  // ----------------------------------------------------------------------
  // Policy engine
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_is_source = IS_SOURCE;
    next_is_dfp = IS_DFP;
    next_vconn = VCONN_ON;
    next_contract = CONTRACT;
    next_in_mode = IN_MODE;
    next_err = ERROR_RECOVERY;
    next_cable = CABLE_CUR;
    next_pd_cap = pd_cap;
    next_hcnt = hcnt;
    next_tx_v = 1'b0;
    next_tx_a = PDSP_SOP;
    next_tx_m = PDSP_MSG_NONE;
    next_tx_d = 8'h00;
    t_load = 1'b0;
    t_stop = 1'b0;
    t_val = '0;
    if (!ATTACH) begin
      next_st = S_IDLE;
      next_contract = 1'b0;
      next_pd_cap = 1'b0;
      next_in_mode = 1'b0;
      t_stop = 1'b1;
    end else if (rx_hrst && st != S_ERR) begin
      next_pd_cap = 1'b1;
      next_st = S_CAPS;
      next_contract = 1'b0;
      next_in_mode = 1'b0;
      next_is_dfp = next_is_source;
      next_vconn = 1'b1;
      t_load = 1'b1;
      t_val = PDSP_TMR_W'(1);
    end else if (rx_sop && cc.snk_msg == PDSP_MSG_REQUEST &&
                 st inside {S_CAPS, S_NEGO, S_WAITACK}) begin
      // The far end answers an offer with its Request, which implies the GoodCRC
      next_pd_cap = 1'b1;
      next_tx_v = 1'b1;
      next_tx_m = (cc.snk_data <= CABLE_CUR) ? PDSP_MSG_ACCEPT : PDSP_MSG_REJECT;
      next_st = (cc.snk_data <= CABLE_CUR) ? S_TRANS : S_NEGO;
      next_hcnt = '0;
      t_load = 1'b1;
      t_val = PDSP_TMR_W'(NORESP_CYC);
    end else begin
      unique case (st)
        S_IDLE: begin
          // Pull-up end comes up Source, DFP and VCONN supplier
          next_is_source = 1'b1;
          next_is_dfp = 1'b1;
          next_vconn = 1'b1;
          next_cable = PDSP_DEF_CUR;
          next_hcnt = '0;
          next_err = 1'b0;
          next_tx_v = 1'b1;
          next_tx_a = PDSP_SOP_P;
          next_tx_m = PDSP_MSG_DISC_ID;
          next_st = S_PROBE;
          t_load = 1'b1;
          t_val = PDSP_TMR_W'(RECV_CYC);
        end
        S_PROBE: begin
          if (cc.snk_valid && cc.snk_addr == PDSP_SOP_P && VCONN_ON) begin
            next_cable = cc.snk_data;
            next_st = S_CAPS;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(1);
          end else if (rx_sop || t_exp) begin
            // Dropped plug exchange is abandoned, never reset
            next_st = S_CAPS;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(1);
          end
        end
        S_CAPS: begin
          if (rx_ack) begin
            next_pd_cap = 1'b1;
            next_st = S_NEGO;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(NORESP_CYC);
          end else if (t_exp) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_SRC_CAP;
            next_tx_d = CABLE_CUR;
            t_load = 1'b1;
            next_st = (hcnt != '0) ? S_NEGO : S_CAPS;
            t_val = (hcnt != '0) ? PDSP_TMR_W'(NORESP_CYC) : PDSP_TMR_W'(CAP_CYC);
          end
        end
        S_NEGO: begin
          if (t_exp) begin
            next_st = S_HARD;
          end
        end
        S_TRANS: begin
          if (SUPPLY_FAULT) begin
            next_st = S_HARD;
          end else if (SUPPLY_READY) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_PS_RDY;
            next_contract = 1'b1;
            next_st = S_READY;
          end
        end
        S_READY: begin
          if (rx_sop && cc.snk_msg == PDSP_MSG_SOFT_RST) begin
            next_st = S_NEGO;
            t_stop = 1'b1;
          end else if (CAPS_CHANGED) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_SRC_CAP;
            next_tx_d = CABLE_CUR;
            next_st = S_WAITACK;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(RECV_CYC);
          end else if (REQ_PR_SWAP) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_PR_SWAP;
            next_is_source = 1'b0;
            next_contract = 1'b0;
          end else if (REQ_DR_SWAP) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_DR_SWAP;
            next_is_dfp = !IS_DFP;
          end else if (REQ_VC_SWAP) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_VC_SWAP;
            next_vconn = 1'b1;
            next_st = S_VCSWAP;
          end else if (REQ_MODE && IS_DFP && VCONN_ON && !plug_busy) begin
            next_tx_v = 1'b1;
            next_tx_a = PDSP_SOP_P;
            next_tx_m = PDSP_MSG_MODE;
            next_in_mode = !IN_MODE;
          end
        end
        S_VCSWAP: begin
          // Release only once the peer drives VCONN
          if (VCONN_PEER_ON) begin
            next_vconn = !VCONN_ON;
            next_st = S_READY;
          end
        end
        S_WAITACK: begin
          if (rx_ack) begin
            next_st = S_READY;
            t_stop = 1'b1;
          end else if (t_exp) begin
            next_tx_v = 1'b1;
            next_tx_m = PDSP_MSG_SOFT_RST;
            next_st = S_SOFT;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(RECV_CYC);
          end
        end
        S_SOFT: begin
          if (rx_ack) begin
            next_st = S_NEGO;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(NORESP_CYC);
          end else if (t_exp) begin
            next_st = S_HARD;
          end
        end
        S_HARD: begin
          if (hcnt == 2'(HRST_MAX + 1)) begin
            next_st = S_ERR;
            next_err = 1'b1;
          end else begin
            next_tx_v = 1'b1;
            next_tx_a = PDSP_HRST;
            next_hcnt = hcnt + 2'h1;
            next_contract = 1'b0;
            next_in_mode = 1'b0;
            next_is_dfp = IS_SOURCE;
            next_vconn = 1'b1;
            next_st = S_CAPS;
            t_load = 1'b1;
            t_val = PDSP_TMR_W'(1);
          end
        end
        S_ERR: begin
          next_vconn = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st <= S_IDLE;
      IS_SOURCE <= 1'b1;
      IS_DFP <= 1'b1;
      VCONN_ON <= 1'b0;
      CONTRACT <= 1'b0;
      IN_MODE <= 1'b0;
      ERROR_RECOVERY <= 1'b0;
      CABLE_CUR <= PDSP_DEF_CUR;
      pd_cap <= 1'b0;
      hcnt <= '0;
      tx_v <= 1'b0;
      tx_a <= PDSP_SOP;
      tx_m <= PDSP_MSG_NONE;
      tx_d <= 8'h00;
    end else begin
      st <= next_st;
      IS_SOURCE <= next_is_source;
      IS_DFP <= next_is_dfp;
      VCONN_ON <= next_vconn;
      CONTRACT <= next_contract;
      IN_MODE <= next_in_mode;
      ERROR_RECOVERY <= next_err;
      CABLE_CUR <= next_cable;
      pd_cap <= next_pd_cap;
      hcnt <= next_hcnt;
      tx_v <= next_tx_v;
      tx_a <= next_tx_a;
      tx_m <= next_tx_m;
      tx_d <= next_tx_d;
    end
  end
endmodule : pdsp_source

// ===== src/pdsp_partner.sv
// Far end: sink port partner and cable plugs behind the CC wire.
// Assumes the source end drives at most one message per cycle.
`timescale 1ns/1ps
module pdsp_partner import pdsp_pkg::*; (
  input  wire logic   CLK,
  input  wire logic   RESET,
  input  wire logic [7:0] REQ_CUR,
  input  wire logic [7:0] PLUG_CUR,
  input  wire logic   PLUG_NEAR_VCONN,
  input  wire logic   PLUG_PP_EN,
  input  wire logic   HOLD_VCONN,
  pdsp_cc_if.partner  cc,
  output logic        SNK_CONTRACT,
  output logic        SNK_VCONN
);
  logic       rx_v, next_rx_v;
  pdsp_addr_e rx_a, next_rx_a;
  pdsp_msg_e  rx_m, next_rx_m;
  logic [7:0] rx_d, next_rx_d;
  logic       next_contract, next_vconn;
  assign cc.snk_valid = rx_v;
  assign cc.snk_addr  = rx_a;
  assign cc.snk_msg   = rx_m;
  assign cc.snk_data  = rx_d;
  always_comb begin
    next_rx_v = 1'b0;
    next_rx_a = PDSP_SOP;
    next_rx_m = PDSP_MSG_NONE;
    next_rx_d = 8'h00;
    next_contract = SNK_CONTRACT;
    next_vconn = SNK_VCONN;
    if (cc.src_valid) begin
      unique case (cc.src_addr)
        PDSP_SOP: begin
          next_rx_v = 1'b1;
          next_rx_m = PDSP_MSG_GOODCRC;
          if (cc.src_msg == PDSP_MSG_SRC_CAP) begin
            next_rx_m = PDSP_MSG_REQUEST;
            next_rx_d = REQ_CUR;
          end
          if (cc.src_msg == PDSP_MSG_PS_RDY) next_contract = 1'b1;
          if (cc.src_msg == PDSP_MSG_PR_SWAP) next_contract = 1'b0;
          // Both drive VCONN, this end holds until told to drop
          if (cc.src_msg == PDSP_MSG_VC_SWAP) next_vconn = 1'b1;
        end
        PDSP_SOP_P: begin
          // Sink never answers plug traffic; the near plug does
          if (PLUG_NEAR_VCONN) begin
            next_rx_v = 1'b1;
            next_rx_a = PDSP_SOP_P;
            next_rx_m = PDSP_MSG_GOODCRC;
            next_rx_d = PLUG_CUR;
          end
        end
        PDSP_SOP_PP: begin
          if (PLUG_PP_EN && !PLUG_NEAR_VCONN) begin
            next_rx_v = 1'b1;
            next_rx_a = PDSP_SOP_PP;
            next_rx_m = PDSP_MSG_GOODCRC;
            next_rx_d = PLUG_CUR;
          end
        end
        PDSP_HRST: begin
          next_contract = 1'b0;
          next_vconn = 1'b0;
        end
      endcase
    end else if (!HOLD_VCONN) begin
      next_vconn = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_v <= 1'b0;
      rx_a <= PDSP_SOP;
      rx_m <= PDSP_MSG_NONE;
      rx_d <= 8'h00;
      SNK_CONTRACT <= 1'b0;
      SNK_VCONN <= 1'b0;
    end else begin
      rx_v <= next_rx_v;
      rx_a <= next_rx_a;
      rx_m <= next_rx_m;
      rx_d <= next_rx_d;
      SNK_CONTRACT <= next_contract;
      SNK_VCONN <= next_vconn;
    end
  end
endmodule : pdsp_partner

// ===== sim/pdsp_cc_asserts.sv
// Checker for the CC interface between the source end and its far end.
// Assumes one clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ps
module pdsp_cc_checker import pdsp_pkg::*; #(
  parameter int HRST_MAX = PDSP_HRST_RETRIES
) (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       src_valid,
  input wire pdsp_addr_e src_addr,
  input wire pdsp_msg_e  src_msg,
  input wire logic [7:0] src_data,
  input wire logic       snk_valid,
  input wire pdsp_addr_e snk_addr,
  input wire pdsp_msg_e  snk_msg,
  input wire logic [7:0] snk_data
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic       acc_seen;
  logic       next_acc_seen;
  logic [3:0] hr_cnt;
  logic [3:0] next_hr_cnt;

  always_comb begin
    next_acc_seen = acc_seen;
    next_hr_cnt   = hr_cnt;
    if (src_valid && src_msg == PDSP_MSG_ACCEPT) next_acc_seen = 1'b1;
    if (src_valid && src_msg == PDSP_MSG_PS_RDY) next_acc_seen = 1'b0;
    if (src_valid && src_addr == PDSP_HRST) begin
      next_acc_seen = 1'b0;
      next_hr_cnt   = hr_cnt + 4'h1;
    end
    // Any answer from the far end ends a run of unanswered hard resets
    if (snk_valid) next_hr_cnt = 4'h0;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      acc_seen <= 1'b0;
      hr_cnt   <= 4'h0;
    end else begin
      acc_seen <= next_acc_seen;
      hr_cnt   <= next_hr_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------------
  sequence s_caps_out;
    src_valid && src_addr == PDSP_SOP && src_msg == PDSP_MSG_SRC_CAP;
  endsequence
  sequence s_req_in;
    snk_valid && snk_msg == PDSP_MSG_REQUEST;
  endsequence
  sequence s_answer_out;
    src_valid && (src_msg == PDSP_MSG_ACCEPT || src_msg == PDSP_MSG_REJECT);
  endsequence

  caps_reply_a: assert property (s_caps_out |=> s_req_in)
    else $error("capabilities not answered by a request");
  req_answer_a: assert property (s_req_in |-> ##[1:2] s_answer_out)
    else $error("request not answered by accept or reject");
  psrdy_order_a: assert property (src_valid && src_msg == PDSP_MSG_PS_RDY |-> acc_seen)
    else $error("ready message without a prior accept");
  msg_addr_a: assert property (src_valid && src_msg inside {PDSP_MSG_SRC_CAP,
      PDSP_MSG_ACCEPT, PDSP_MSG_PS_RDY} |-> src_addr == PDSP_SOP)
    else $error("contract message not on port address");
  plug_sp_a: assert property (snk_valid && snk_addr == PDSP_SOP_P |->
      $past(src_valid) && $past(src_addr) == PDSP_SOP_P)
    else $error("single-prime reply without a single-prime request");
  plug_dp_a: assert property (snk_valid && snk_addr == PDSP_SOP_PP |->
      $past(src_valid) && $past(src_addr) == PDSP_SOP_PP)
    else $error("double-prime reply without a double-prime request");
  plug_sop_a: assert property (src_valid && src_addr == PDSP_SOP |=>
      !(snk_valid && snk_addr inside {PDSP_SOP_P, PDSP_SOP_PP}))
    else $error("plug answered port traffic");
  hr_limit_a: assert property (hr_cnt <= 4'(HRST_MAX + 1))
    else $error("too many unanswered hard resets");
endmodule : pdsp_cc_checker

// ===== sim/pd_source_port_policy_tb_top.sv
// Testbench: source and far end joined by one CC interface, plus a second
// source whose far side is driven by the bench to play a silent partner.
`timescale 1ns/1ps
module pd_source_port_policy_tb_top;
  import pdsp_pkg::*;
  localparam int CAP = 20;
  localparam int RECV = 5;
  localparam int NORESP = 40;
  localparam int HMAX = 2;
  logic       clk;
  logic       reset;
  logic       attach, attach_b, caps_changed, supply_ready, supply_fault;
  logic       req_pr, req_dr, req_vc, req_mode, plug_near, plug_pp, hold_vconn;
  logic [7:0] req_cur, plug_cur, cable_cur, cable_cur_b;
  logic       is_source, is_dfp, vconn_on, contract, in_mode, err_rec;
  logic       snk_contract, snk_vconn, is_dfp_b, vconn_on_b, err_rec_b, seen;
  int         checks;
  int         mismatches;

  pdsp_cc_if cc ();
  pdsp_cc_if cc2 ();
  pdsp_source #(.CAP_CYC(CAP), .RECV_CYC(RECV), .NORESP_CYC(NORESP), .HRST_MAX(HMAX))
    u_pdsp_source (.CLK(clk), .RESET(reset), .ATTACH(attach), .CAPS_CHANGED(caps_changed),
    .SUPPLY_READY(supply_ready), .SUPPLY_FAULT(supply_fault), .REQ_PR_SWAP(req_pr),
    .REQ_DR_SWAP(req_dr), .REQ_VC_SWAP(req_vc), .REQ_MODE(req_mode),
    .VCONN_PEER_ON(snk_vconn), .cc(cc.source), .IS_SOURCE(is_source), .IS_DFP(is_dfp),
    .VCONN_ON(vconn_on), .CONTRACT(contract), .IN_MODE(in_mode),
    .ERROR_RECOVERY(err_rec), .CABLE_CUR(cable_cur));
  pdsp_partner u_pdsp_partner (.CLK(clk), .RESET(reset), .REQ_CUR(req_cur),
    .PLUG_CUR(plug_cur), .PLUG_NEAR_VCONN(plug_near), .PLUG_PP_EN(plug_pp),
    .HOLD_VCONN(hold_vconn), .cc(cc.partner), .SNK_CONTRACT(snk_contract),
    .SNK_VCONN(snk_vconn));
  pdsp_source #(.CAP_CYC(CAP), .RECV_CYC(RECV), .NORESP_CYC(NORESP), .HRST_MAX(HMAX))
    u_pdsp_source_b (.CLK(clk), .RESET(reset), .ATTACH(attach_b),
    .CAPS_CHANGED(caps_changed), .SUPPLY_READY(supply_ready), .SUPPLY_FAULT(supply_fault),
    .REQ_PR_SWAP(req_pr), .REQ_DR_SWAP(req_dr), .REQ_VC_SWAP(req_vc), .REQ_MODE(req_mode),
    .VCONN_PEER_ON(1'b0), .cc(cc2.source), .IS_SOURCE(), .IS_DFP(is_dfp_b),
    .VCONN_ON(vconn_on_b), .CONTRACT(), .IN_MODE(), .ERROR_RECOVERY(err_rec_b),
    .CABLE_CUR(cable_cur_b));
  pdsp_cc_checker #(.HRST_MAX(HMAX)) u_pdsp_cc_checker (.CLK(clk), .RESET(reset),
    .src_valid(cc.src_valid), .src_addr(cc.src_addr), .src_msg(cc.src_msg),
    .src_data(cc.src_data), .snk_valid(cc.snk_valid), .snk_addr(cc.snk_addr),
    .snk_msg(cc.snk_msg), .snk_data(cc.snk_data));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  // Hard reset carries no message code, so only its address is matched
  task automatic wait_src(input logic b, input pdsp_addr_e a, input pdsp_msg_e m,
                          input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clk);
      if (b) seen = cc2.src_valid === 1'b1 && cc2.src_addr === a &&
                    (a == PDSP_HRST || cc2.src_msg === m);
      else seen = cc.src_valid === 1'b1 && cc.src_addr === a &&
                  (a == PDSP_HRST || cc.src_msg === m);
    end
  endtask : wait_src

  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: caps_changed <= 1'b1;
      1: req_dr <= 1'b1;
      2: req_vc <= 1'b1;
      default: req_mode <= 1'b1;
    endcase
    @(posedge clk);
    {caps_changed, req_dr, req_vc, req_mode} <= 4'h0;
  endtask : pulse

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_silent;
    int n;
    int hrs;
    attach_b <= 1'b1;
    wait_src(1'b1, PDSP_SOP, PDSP_MSG_SRC_CAP, 200);
    chk_bit("first caps", 1'b1, seen);
    chk_byte("default cable current", 8'h1e, cable_cur_b);
    for (n = 1; n < 3 * CAP; n++) begin
      @(posedge clk);
      if (cc2.src_valid === 1'b1 && cc2.src_msg === PDSP_MSG_SRC_CAP) break;
    end
    chk_bit("caps interval", 1'b1, n == CAP || n == CAP + 1);
    cc2.snk_valid <= 1'b1;
    cc2.snk_msg   <= PDSP_MSG_GOODCRC;
    @(posedge clk);
    cc2.snk_valid <= 1'b0;
    cc2.snk_data  <= ~cc2.snk_data;
    hrs = 0;
    repeat (8 * NORESP + 50) begin
      @(posedge clk);
      if (cc2.src_valid === 1'b1 && cc2.src_addr === PDSP_HRST) hrs++;
    end
    chk_byte("hard reset count", 8'(HMAX + 1), 8'(hrs));
    chk_bit("error recovery", 1'b1, err_rec_b);
    chk_bit("vconn off in recovery", 1'b0, vconn_on_b);
    chk_bit("dfp after hard reset", 1'b1, is_dfp_b);
  endtask : t_silent

  task automatic t_attach;
    chk_byte("reset cable current", 8'h1e, cable_cur);
    attach <= 1'b1;
    wait_src(1'b0, PDSP_SOP_P, PDSP_MSG_DISC_ID, 10);
    chk_bit("cable probe", 1'b1, seen);
    chk_bit("vconn at probe", 1'b1, vconn_on);
    chk_bit("source role", 1'b1, is_source);
    chk_bit("dfp role", 1'b1, is_dfp);
    chk_bit("sink vconn", 1'b0, snk_vconn);
    wait_src(1'b0, PDSP_SOP, PDSP_MSG_SRC_CAP, 200);
    chk_bit("caps sent", 1'b1, seen);
    chk_byte("probed cable current", 8'h32, cable_cur);
    wait_src(1'b0, PDSP_SOP, PDSP_MSG_ACCEPT, 10);
    chk_bit("accept", 1'b1, seen);
    repeat (3) @(posedge clk);
    chk_bit("no contract before supply", 1'b0, contract);
    supply_ready <= 1'b1;
    for (int i = 0; i < 50 && contract !== 1'b1; i++) @(posedge clk);
    chk_bit("contract", 1'b1, contract);
    @(posedge clk);
    chk_bit("sink contract", 1'b1, snk_contract);
  endtask : t_attach

  task automatic t_swap_mode;
    pulse(1);
    for (int i = 0; i < 30 && is_dfp !== 1'b0; i++) @(posedge clk);
    chk_bit("ufp after swap", 1'b0, is_dfp);
    chk_bit("source kept", 1'b1, is_source);
    chk_bit("vconn kept", 1'b1, vconn_on);
    pulse(3);
    repeat (30) @(posedge clk);
    chk_bit("no mode as ufp", 1'b0, in_mode);
    pulse(1);
    for (int i = 0; i < 30 && is_dfp !== 1'b1; i++) @(posedge clk);
    chk_bit("dfp again", 1'b1, is_dfp);
    pulse(3);
    for (int i = 0; i < 30 && in_mode !== 1'b1; i++) @(posedge clk);
    chk_bit("mode as dfp", 1'b1, in_mode);
  endtask : t_swap_mode

  task automatic t_vconn_swap;
    pulse(2);
    for (int i = 0; i < 60 && vconn_on !== 1'b0; i++) @(posedge clk);
    chk_bit("vconn handed over", 1'b0, vconn_on);
    chk_bit("peer vconn at release", 1'b1, snk_vconn);
    chk_bit("source after vconn swap", 1'b1, is_source);
    chk_bit("dfp after vconn swap", 1'b1, is_dfp);
  endtask : t_vconn_swap

  task automatic t_fault;
    supply_ready <= 1'b0;
    pulse(0);
    wait_src(1'b0, PDSP_SOP, PDSP_MSG_SRC_CAP, 10);
    chk_bit("caps on change", 1'b1, seen);
    wait_src(1'b0, PDSP_SOP, PDSP_MSG_ACCEPT, 10);
    chk_bit("accept on renegotiation", 1'b1, seen);
    supply_fault <= 1'b1;
    wait_src(1'b0, PDSP_HRST, PDSP_MSG_NONE, 20);
    chk_bit("hard reset on fault", 1'b1, seen);
    supply_fault <= 1'b0;
    repeat (5) @(posedge clk);
    chk_bit("modes exited", 1'b0, in_mode);
    chk_bit("dfp restored", 1'b1, is_dfp);
    chk_bit("contract dropped", 1'b0, contract);
    for (int i = 0; i < 20 && vconn_on !== 1'b1; i++) @(posedge clk);
    chk_bit("vconn restored", 1'b1, vconn_on);
  endtask : t_fault

  // ----------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    {attach, attach_b, caps_changed, supply_ready, supply_fault} = 5'h00;
    {req_pr, req_dr, req_vc, req_mode, plug_pp} = 5'h00;
    plug_near  = 1'b1;
    hold_vconn = 1'b1;
    req_cur    = 8'h14;
    plug_cur   = 8'h32;
    cc2.snk_valid = 1'b0;
    cc2.snk_addr  = PDSP_SOP;
    cc2.snk_msg   = PDSP_MSG_NONE;
    cc2.snk_data  = 8'h5a;
    checks     = 0;
    mismatches = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_silent();
    t_attach();
    t_swap_mode();
    t_vconn_swap();
    t_fault();
    end_sim();
  end

  // A run takes under a thousand cycles; wide margin
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule : pd_source_port_policy_tb_top
